// ===== logic/scdl_aes_dec.sv
// iterative AES-128 block decryptor, one round per clock
`timescale 1ns/1ps
module scdl_aes_dec (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [127:0] key,
  input wire logic [127:0] din,
  output logic [127:0] dout,
  output logic done
);
  import scdl_pkg::*;

  typedef enum logic [1:0] {a_idle, a_exp, a_add, a_rnd} scdl_ast_t;
  typedef struct packed {
    scdl_ast_t st;
    logic [3:0] rnd; // key step or round index
    logic [7:0] rc; // round constant of the next forward key step from the key now held
    logic [127:0] rk; // current round key
    logic [127:0] blk; // working block
    logic done;
  } scdl_aes_t;

  scdl_aes_t s; // registered state
  scdl_aes_t next_s; // next state

  // field doubling
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? AES_POLY : 8'h00);
  endfunction

  // inverse of field doubling, used to walk the round constant back
  function automatic logic [7:0] ixt(input logic [7:0] a);
    return a[0] ? (((a ^ AES_POLY) >> 1) | 8'h80) : (a >> 1);
  endfunction

  // field product
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  // field inverse as a^254; zero maps to zero; costs area but needs no table
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = a;
    for (int i = 0; i < 7; i++)
    begin
      p = gm(p, p);
      r = gm(r, p);
    end
    return r;
  endfunction

  // rotate a byte left
  function automatic logic [7:0] rl(input logic [7:0] b, input int n);
    logic [15:0] d;
    d = {b, b} << n;
    return d[15:8];
  endfunction

  // forward substitution, for the key schedule
  function automatic logic [7:0] sb(input logic [7:0] a);
    logic [7:0] y;
    y = ginv(a);
    return y ^ rl(y, 1) ^ rl(y, 2) ^ rl(y, 3) ^ rl(y, 4) ^ AES_AFF;
  endfunction

  // inverse substitution, for the block
  function automatic logic [7:0] isb(input logic [7:0] a);
    return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ AES_IAFF);
  endfunction

  // rotated, substituted word plus round constant
  function automatic logic [31:0] kt(input logic [31:0] w, input logic [7:0] rc);
    return {sb(w[23:16]) ^ rc, sb(w[15:8]), sb(w[7:0]), sb(w[31:24])};
  endfunction

  // one forward key step
  function automatic logic [127:0] kfwd(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    w0 = k[127:96] ^ kt(k[31:0], rc);
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    return {w0, w1, w2, k[31:0] ^ w2};
  endfunction

  // one backward key step
  function automatic logic [127:0] kback(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] p3;
    p3 = k[31:0] ^ k[63:32];
    return {k[127:96] ^ kt(p3, rc), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], p3};
  endfunction

  // inverse round: shift, substitute, add key, optionally unmix columns
  function automatic logic [127:0] iround(input logic [127:0] b, input logic [127:0] k, input logic mix);
    logic [127:0] t;
    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] a3;
    t = '0;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        t[8*(15-(r+4*c)) +: 8] = isb(b[8*(15-(r+4*((c-r+4)%4))) +: 8]);
    t = t ^ k;
    if (mix)
      for (int c = 0; c < 4; c++)
      begin
        a0 = t[8*(15-4*c) +: 8];
        a1 = t[8*(14-4*c) +: 8];
        a2 = t[8*(13-4*c) +: 8];
        a3 = t[8*(12-4*c) +: 8];
        t[8*(15-4*c) +: 8] = gm(a0, 8'h0e) ^ gm(a1, 8'h0b) ^ gm(a2, 8'h0d) ^ gm(a3, 8'h09);
        t[8*(14-4*c) +: 8] = gm(a0, 8'h09) ^ gm(a1, 8'h0e) ^ gm(a2, 8'h0b) ^ gm(a3, 8'h0d);
        t[8*(13-4*c) +: 8] = gm(a0, 8'h0d) ^ gm(a1, 8'h09) ^ gm(a2, 8'h0e) ^ gm(a3, 8'h0b);
        t[8*(12-4*c) +: 8] = gm(a0, 8'h0b) ^ gm(a1, 8'h0d) ^ gm(a2, 8'h09) ^ gm(a3, 8'h0e);
      end
    return t;
  endfunction

  // expand to the last round key, then run the rounds backward
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      a_idle:
        if (start)
        begin
          next_s.rk = key;
          next_s.blk = din;
          next_s.rc = AES_RC_FIRST;
          next_s.rnd = 4'h0;
          next_s.st = a_exp;
        end
      a_exp:
      begin
        next_s.rk = kfwd(s.rk, s.rc);
        next_s.rc = xt(s.rc);
        next_s.rnd = s.rnd + 4'h1;
        if (s.rnd == AES_LAST_RND) next_s.st = a_add;
      end
      a_add:
      begin
        next_s.blk = s.blk ^ s.rk;
        next_s.rc = ixt(s.rc);
        next_s.rk = kback(s.rk, ixt(s.rc));
        next_s.rnd = AES_LAST_RND;
        next_s.st = a_rnd;
      end
      a_rnd:
      begin
        next_s.blk = iround(s.blk, s.rk, s.rnd != 4'h0);
        if (s.rnd == 4'h0)
        begin
          next_s.done = 1'b1;
          next_s.st = a_idle;
        end
        else
        begin
          next_s.rc = ixt(s.rc);
          next_s.rk = kback(s.rk, ixt(s.rc));
          next_s.rnd = s.rnd - 4'h1;
        end
      end
      default: next_s.st = a_idle;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst) s <= '0;
    else s <= next_s;
  end

  assign dout = s.blk;
  assign done = s.done;

  // a block accepted in idle comes back exactly 22 cycles later
  block_latency_a: assert property (@(posedge clk) disable iff (rst)
    (start && s.st == a_idle) |-> ##22 done)
    else $error("decryptor latency wrong");

  // completion is a single-cycle pulse
  done_pulse_a: assert property (@(posedge clk) disable iff (rst)
    done |=> !done)
    else $error("done longer than one cycle");
endmodule // scdl_aes_dec

// ===== logic/scdl_loader.sv
// secure configuration loader: link capture, key fuse control, decrypt or bypass, header check
`timescale 1ns/1ps
module scdl_loader (
  input wire logic clk,
  input wire logic rst,
  input wire logic lnk_clk,
  input wire logic config_restart_n,
  input wire logic [2:0] load_mode,
  input wire logic [7:0] lnk_data,
  input wire logic lnk_valid,
  input wire logic lnk_last,
  output logic lnk_ready,
  input wire logic [127:0] fuse_key,
  input wire logic fuse_blown,
  input wire logic key_prog_wr,
  input wire logic [127:0] key_prog_data,
  output logic fuse_burn,
  output logic [127:0] fuse_burn_data,
  output scdl_pkg::scdl_word_t cfg_word,
  output logic cfg_valid,
  output logic cfg_done,
  output logic cfg_error
);
  import scdl_pkg::*;

  // link-side state, clocked by the host's load clock
  typedef struct packed {
    logic clr_s1; // clear level, first stage
    logic clr_s2; // clear level, second stage
    logic ser_s1; // serial-scheme level, first stage
    logic ser_s2; // serial-scheme level, second stage
    logic ack_s1; // ack toggle, first stage
    logic ack_s2; // ack toggle, second stage
    logic req; // request toggle toward the core
    logic busy; // block handed over, not yet acknowledged
    logic ready; // may take a beat
    logic cleared; // clear has taken effect here, echoed back to the core
    logic [7:0] cnt; // bits gathered
    logic [127:0] sh; // gathering register
    scdl_word_t hold; // block on offer to the core
  } scdl_lnk_t;

  // core states
  typedef enum logic [2:0] {st_fuse, st_idle, st_wait, st_dec, st_done, st_err} scdl_st_t;

  // core-side state
  typedef struct packed {
    scdl_st_t st;
    logic rs1; // restart pin, first stage
    logic rs2; // restart pin, second stage
    logic [2:0] md1; // mode pins, first stage
    logic [2:0] md2; // mode pins, second stage
    logic rq1; // request toggle, first stage
    logic rq2; // request toggle, second stage
    logic cl1; // link clear echo, first stage
    logic cl2; // link clear echo, second stage
    logic ack; // ack toggle toward the link
    logic lnk_clr; // holds the link side cleared
    logic serial; // scheme is bit-serial
    logic blown; // key fuses burnt
    logic [127:0] key; // key image from the fuses
    logic first; // next block is the header
    scdl_word_t word; // block taken from the link
    logic aes_go; // start pulse to the decryptor
    logic burn; // fuse burn pulse
    logic [127:0] burn_data; // value to burn
    scdl_word_t cfg; // block to the configuration array
    logic cfg_valid;
    logic done;
    logic error;
  } scdl_sys_t;

  scdl_lnk_t l; // link registers
  scdl_lnk_t next_l; // link next value
  scdl_sys_t s; // core registers
  scdl_sys_t next_s; // core next value
  logic [127:0] aes_out; // decrypted block
  logic aes_done; // decrypted block ready
  logic new_word; // link offers an unread block
  logic res_go; // a result block is to be judged
  logic [127:0] res_data; // decrypted or bypassed block
  logic res_last; // result closes the stream
  logic [7:0] step; // bits per link beat
  logic [7:0] cnt_n; // bit count after this beat
  logic [127:0] sh_n; // gathering register after this beat

  // the decryptor; only ever fed through the core, it has no way back out to the pins
  scdl_aes_dec u_dec (
    .clk(clk),
    .rst(rst),
    .start(s.aes_go),
    .key(s.key),
    .din(s.word.data),
    .dout(aes_out),
    .done(aes_done)
  );

  // link side: gather beats into blocks and offer them by toggle handshake
  always_comb
  begin
    next_l = l;
    next_l.clr_s1 = s.lnk_clr;
    next_l.clr_s2 = l.clr_s1;
    next_l.ser_s1 = s.serial;
    next_l.ser_s2 = l.ser_s1;
    next_l.ack_s1 = s.ack;
    next_l.ack_s2 = l.ack_s1;
    next_l.cleared = l.clr_s2;
    step = l.ser_s2 ? SER_STEP : PAR_STEP;
    cnt_n = l.cnt + step;
    sh_n = l.ser_s2 ? {l.sh[126:0], lnk_data[0]} : {l.sh[119:0], lnk_data};
    if (l.clr_s2)
    begin
      // clock may stop between frames, so clearing rides on the frame's own edges
      next_l.cnt = 8'h00;
      next_l.busy = 1'b0;
      next_l.req = l.ack_s2;
    end
    else
    begin
      if (l.busy && (l.ack_s2 == l.req)) next_l.busy = 1'b0;
      if (lnk_valid && l.ready)
      begin
        next_l.sh = sh_n;
        next_l.cnt = cnt_n;
        if (cnt_n == WORD_BITS || lnk_last)
        begin
          // short final block keeps its bits at the low end
          next_l.hold.data = sh_n;
          next_l.hold.last = lnk_last;
          next_l.req = ~l.req;
          next_l.busy = 1'b1;
          next_l.cnt = 8'h00;
        end
      end
    end
    // no buffer: the host stalls while a block waits for the core
    next_l.ready = !next_l.busy && !l.clr_s2;
  end

  // link registers carry no reset; the clear level settles them once the host clocks
  always_ff @(posedge lnk_clk)
  begin
    l <= next_l;
  end

  // result of the current block, from the decryptor or straight from the link
  always_comb
  begin
    new_word = s.rq2 != s.ack;
    if (s.st == st_dec)
    begin
      res_go = aes_done;
      res_data = aes_out;
      res_last = s.word.last;
    end
    else
    begin
      res_go = (s.st == st_wait) && new_word && !s.blown;
      res_data = l.hold.data;
      res_last = l.hold.last;
    end
  end

  // core sequencer
  always_comb
  begin
    next_s = s;
    next_s.rs1 = config_restart_n;
    next_s.rs2 = s.rs1;
    next_s.md1 = load_mode;
    next_s.md2 = s.md1;
    next_s.rq1 = l.req;
    next_s.rq2 = s.rq1;
    next_s.cl1 = l.cleared;
    next_s.cl2 = s.cl1;
    next_s.aes_go = 1'b0;
    next_s.burn = 1'b0;
    next_s.cfg_valid = 1'b0;
    case (s.st)
      st_fuse:
      begin
        // fuse image caught once, after reset is released
        next_s.blown = fuse_blown;
        next_s.key = fuse_key;
        next_s.st = st_idle;
      end
      st_idle:
      begin
        next_s.lnk_clr = 1'b1;
        // burning only while no load runs; once burnt, writes are dropped
        if (key_prog_wr && !s.blown)
        begin
          next_s.burn = 1'b1;
          next_s.burn_data = key_prog_data;
          next_s.blown = 1'b1;
          next_s.key = key_prog_data;
        end
        else if (s.rs2)
        begin
          next_s.serial = scdl_serial(scdl_mode_t'(s.md2));
          if (s.blown && !scdl_secure_ok(scdl_mode_t'(s.md2)))
          begin
            next_s.st = st_err;
            next_s.error = 1'b1;
          end
          else if (s.cl2)
          begin
            // the link clock may have been parked, so the clear is held until the link reports it seen
            next_s.lnk_clr = 1'b0;
            next_s.first = 1'b1;
            next_s.st = st_wait;
          end
        end
      end
      st_wait:
        if (new_word)
        begin
          next_s.ack = s.rq2;
          next_s.word = l.hold;
          if (s.blown)
          begin
            next_s.aes_go = 1'b1;
            next_s.st = st_dec;
          end
        end
      st_dec: ;
      st_done: ;
      st_err: ;
      default: next_s.st = st_idle;
    endcase
    // judge a finished block: header first, then payload to the array
    if (res_go)
    begin
      next_s.st = st_wait;
      if (s.first)
      begin
        next_s.first = 1'b0;
        if (res_data != HDR_MARK)
        begin
          next_s.st = st_err;
          next_s.error = 1'b1;
        end
        else if (res_last) next_s.st = st_done;
      end
      else
      begin
        next_s.cfg_valid = 1'b1;
        next_s.cfg.data = res_data;
        next_s.cfg.last = res_last;
        if (res_last) next_s.st = st_done;
      end
      if (next_s.st == st_done) next_s.done = 1'b1;
    end
    // restart low aborts any load and clears the report
    if (!s.rs2 && s.st != st_fuse && s.st != st_idle)
    begin
      next_s.st = st_idle;
      next_s.lnk_clr = 1'b1;
      next_s.done = 1'b0;
      next_s.error = 1'b0;
      next_s.cfg_valid = 1'b0;
    end
  end

  // core register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.lnk_clr <= 1'b1;
    end
    else s <= next_s;
  end

  // outputs straight from flip-flops; no read port exists for loaded data
  assign lnk_ready = l.ready;
  assign fuse_burn = s.burn;
  assign fuse_burn_data = s.burn_data;
  assign cfg_word = s.cfg;
  assign cfg_valid = s.cfg_valid;
  assign cfg_done = s.done;
  assign cfg_error = s.error;

  // a keyed device starts the decryptor on every taken block
  decrypt_used_a: assert property (@(posedge clk) disable iff (rst)
    (s.st == st_wait && new_word && s.blown && s.rs2) |=> (s.aes_go && s.st == st_dec))
    else $error("keyed block not sent to decryptor");

  // an unkeyed device passes payload unchanged one cycle later
  bypass_path_a: assert property (@(posedge clk) disable iff (rst)
    (s.st == st_wait && new_word && !s.blown && !s.first && s.rs2)
      |=> (cfg_valid && cfg_word.data == $past(l.hold.data)))
    else $error("bypass altered data");

  // a bad header after decryption ends in the error state
  header_check_a: assert property (@(posedge clk) disable iff (rst)
    (s.st == st_dec && aes_done && s.first && aes_out != HDR_MARK && s.rs2)
      |=> (cfg_error && s.st == st_err))
    else $error("bad header not refused");

  // payload only leaves while a load is in progress
  no_readback_a: assert property (@(posedge clk) disable iff (rst)
    cfg_valid |-> $past(s.st == st_wait || s.st == st_dec))
    else $error("data left outside a load");

  // a burnt key is never burnt again
  fuse_once_a: assert property (@(posedge clk) disable iff (rst)
    (s.blown && s.st != st_fuse) |=> !fuse_burn)
    else $error("second fuse burn");

  // a keyed device refuses schemes without decryption
  mode_refuse_a: assert property (@(posedge clk) disable iff (rst)
    (s.st == st_idle && s.rs2 && !key_prog_wr && s.blown && !scdl_secure_ok(scdl_mode_t'(s.md2)))
      |=> cfg_error)
    else $error("unsupported scheme accepted");

  // a supported scheme starts a load without error
  mode_accept_a: assert property (@(posedge clk) disable iff (rst)
    (s.st == st_idle && s.rs2 && !key_prog_wr && s.cl2 && scdl_secure_ok(scdl_mode_t'(s.md2)))
      |=> (s.st == st_wait && !cfg_error))
    else $error("supported scheme refused");

  // an error holds, with no payload, while restart stays high
  error_hold_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_error && s.rs2) |=> (cfg_error && !cfg_valid && !cfg_done))
    else $error("error not held");
endmodule // scdl_loader

// ===== logic/scdl_pkg.sv
// package: constants, carriers and mode checks of the secure configuration loader
// Overview of operation
// - secure streams pass the AES decryptor first
// - decryptor works on whole 128-bit cipher blocks
// - unsecured device bypasses the decryptor unchanged
// - plain or wrong-key stream fails configuration
// - no readback path for loaded content
// - key fuses burn once, later writes ignored
// - decryption offered for parallel, active, passive serial
// - decryption refused for async, test-port, memory-parallel
package scdl_pkg;
  localparam int BLK_W = 128; // cipher block and key width
  localparam logic [3:0] AES_LAST_RND = 4'h9; // index of the last key step / first inverse round
  localparam logic [7:0] AES_POLY = 8'h1b; // field reduction polynomial
  localparam logic [7:0] AES_AFF = 8'h63; // forward affine constant
  localparam logic [7:0] AES_IAFF = 8'h05; // inverse affine constant
  localparam logic [7:0] AES_RC_FIRST = 8'h01; // first round constant
  localparam logic [7:0] WORD_BITS = 8'h80; // bits gathered per block on the link
  localparam logic [7:0] SER_STEP = 8'h01; // bits per serial link beat
  localparam logic [7:0] PAR_STEP = 8'h08; // bits per parallel link beat
  // leading block every stream must carry after decryption; value is arbitrary
  localparam logic [127:0] HDR_MARK = 128'h5a3c_96e1_0f2d_4b87_c3a5_1e69_d2f0_7b48;

  // load scheme as strapped on the mode pins
  typedef enum logic [2:0] {
    fast_parallel_load,
    active_serial_load,
    passive_serial_load,
    async_parallel_load,
    test_port_load,
    fast_parallel_mem_load
  } scdl_mode_t;

  // one block with its end-of-stream mark
  typedef struct packed {
    logic [127:0] data;
    logic last;
  } scdl_word_t;

  // schemes on which a keyed device may load
  function automatic logic scdl_secure_ok(input scdl_mode_t m);
    return (m == fast_parallel_load) || (m == active_serial_load) || (m == passive_serial_load);
  endfunction

  // schemes that deliver one bit per link beat
  function automatic logic scdl_serial(input scdl_mode_t m);
    return (m == active_serial_load) || (m == passive_serial_load);
  endfunction
endpackage

// ===== test/scdl_host_model.sv
// link host model: runs the load clock only inside a frame and hands over beats on ready
`timescale 1ns/1ps
module scdl_host_model (
  output logic lnk_clk,
  output logic [7:0] lnk_data,
  output logic lnk_valid,
  output logic lnk_last,
  input wire logic lnk_ready
);
  logic run = 1'b0; // clock runs only while a frame is open

  // load clock, phase unrelated to the core clock, parked low between frames
  initial
  begin
    lnk_clk = 1'b0;
    lnk_data = 8'h00;
    lnk_valid = 1'b0;
    lnk_last = 1'b0;
    #37.3;
    forever
    begin
      #80;
      lnk_clk = run ? ~lnk_clk : 1'b0;
    end
  end

  // one frame of whole blocks; serial sends msb first, parallel sends byte 127:120 first
  task automatic send(input logic [127:0] blk[$], input logic ser);
    int n;
    int k;
    run = 1'b1;
    // the link clear needs a few edges before the first beat
    repeat (4) @(posedge lnk_clk);
    n = ser ? 128 : 16;
    for (int j = 0; j < blk.size(); j++)
    begin
      for (k = 0; k < n; k++)
      begin
        #1;
        lnk_valid = 1'b1;
        // unused serial bits carry noise so nothing relies on them
        lnk_data = ser ? {7'($urandom()), blk[j][127-k]} : blk[j][127-8*k -: 8];
        lnk_last = (j == blk.size() - 1) && (k == n - 1);
        // beat and qualifiers held until ready is seen high at an edge
        do @(posedge lnk_clk); while (lnk_ready !== 1'b1);
      end
    end
    #1;
    lnk_valid = 1'b0;
    lnk_last = 1'b0;
    lnk_data = ~lnk_data; // released data no longer shows the last beat
    repeat (4) @(posedge lnk_clk);
    run = 1'b0;
  endtask
endmodule // scdl_host_model

// ===== test/tb_top.sv
// self-checking bench of the secure configuration loader
`timescale 1ns/1ps
module tb_top;
  import scdl_pkg::*;
  logic clk, rst, config_restart_n, key_prog_wr, fuse_blown, fuse_burn;
  logic lnk_clk, lnk_valid, lnk_last, lnk_ready, cfg_valid, cfg_done, cfg_error;
  logic key_supply_select_n; // programmer's supply select, low picks the raised level
  logic [2:0] load_mode;
  logic [7:0] lnk_data;
  logic [127:0] fuse_key, key_prog_data, fuse_burn_data, k1;
  scdl_word_t cfg_word;
  scdl_word_t exp_q[$]; // blocks expected on the config side, oldest first
  int errors = 0;
  int cmp_count = 0;

  // core clock, 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  scdl_loader u_dut (.clk(clk), .rst(rst), .lnk_clk(lnk_clk), .config_restart_n(config_restart_n),
    .load_mode(load_mode), .lnk_data(lnk_data), .lnk_valid(lnk_valid), .lnk_last(lnk_last),
    .lnk_ready(lnk_ready), .fuse_key(fuse_key), .fuse_blown(fuse_blown), .key_prog_wr(key_prog_wr),
    .key_prog_data(key_prog_data), .fuse_burn(fuse_burn), .fuse_burn_data(fuse_burn_data),
    .cfg_word(cfg_word), .cfg_valid(cfg_valid), .cfg_done(cfg_done), .cfg_error(cfg_error));

  scdl_host_model u_host (.lnk_clk(lnk_clk), .lnk_data(lnk_data), .lnk_valid(lnk_valid),
    .lnk_last(lnk_last), .lnk_ready(lnk_ready));

  // single compare point
  task automatic check(input logic [128:0] seen, input logic [128:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if ((errors == 0) && (cmp_count > 0))
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // every block pulse is matched against the oldest note
  always @(posedge clk)
  begin
    if (cfg_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1'b1, 1'b0, "unexpected config block");
      else
        check(cfg_word, exp_q.pop_front(), "config block");
    end
    if (fuse_burn === 1'b1)
      check(key_supply_select_n, 1'b0, "burn without raised supply");
  end

  // one burn request; take says whether a pulse must follow
  task automatic burn(input logic [127:0] k, input logic take, input logic [127:0] held);
    @(posedge clk);
    #0.5;
    config_restart_n = 1'b0;
    key_supply_select_n = 1'b0;
    // supply settle and slow test clock shrunk to a few core cycles; the core is idle by then
    repeat (4) @(posedge clk);
    #0.5;
    key_prog_wr = 1'b1;
    key_prog_data = k;
    @(posedge clk);
    #0.5;
    key_prog_wr = 1'b0;
    key_prog_data = ~k;
    check(fuse_burn, take, "burn pulse");
    check(fuse_burn_data, held, "burn data");
    @(posedge clk);
    #0.5;
    check(fuse_burn, 1'b0, "burn pulse width");
    key_supply_select_n = 1'b1;
  endtask

  // restart, then a stream of header plus nblk blocks (none when nblk < 0)
  task automatic load(input int m, input int nblk, input logic err);
    logic [127:0] blk[$];
    scdl_word_t w;
    int t;
    @(posedge clk);
    #0.5;
    config_restart_n = 1'b0;
    load_mode = 3'(m);
    repeat (6) @(posedge clk);
    #0.5;
    check({cfg_done, cfg_error}, 129'h0, "status not cleared");
    config_restart_n = 1'b1;
    if (nblk >= 0)
    begin
      blk.push_back(HDR_MARK);
      for (int i = 0; i < nblk; i++)
      begin
        w.data = {$urandom(), $urandom(), $urandom(), $urandom()};
        w.last = (i == nblk - 1);
        blk.push_back(w.data);
        if (!err)
          exp_q.push_back(w);
      end
      u_host.send(blk, (m == 1) || (m == 2));
    end
    t = 0;
    while (((cfg_done | cfg_error) !== 1'b1) && (t < 400))
    begin
      @(posedge clk);
      t++;
    end
    repeat (2) @(posedge clk);
    #0.5;
    check({cfg_done, cfg_error}, {~err, err}, "load outcome");
  endtask

  // main sequence
  initial
  begin
    void'($urandom(32'h892741a5));
    rst = 1'b1;
    config_restart_n = 1'b0;
    load_mode = 3'h0;
    key_prog_wr = 1'b0;
    key_prog_data = 128'h0;
    key_supply_select_n = 1'b1;
    fuse_blown = 1'b0;
    fuse_key = {$urandom(), $urandom(), $urandom(), $urandom()};
    repeat (12) @(posedge clk);
    #0.5;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #0.5;
    check({fuse_burn, cfg_valid, cfg_done, cfg_error}, 129'h0, "reset outputs");
    // unkeyed device passes every scheme straight through
    for (int m = 0; m < 6; m++)
      load(m, 2, 1'b0);
    // key burnt before any keyed load, once only
    k1 = {$urandom(), $urandom(), $urandom(), $urandom()};
    burn(k1, 1'b1, k1);
    burn(~k1, 1'b0, k1);
    // plaintext header fails after decryption on each secure scheme
    for (int m = 0; m < 3; m++)
      load(m, 0, 1'b1);
    // schemes without decryption are refused on a keyed device
    for (int m = 3; m < 6; m++)
      load(m, -1, 1'b1);
    // fuses already blown at reset refuse any burn
    fuse_blown = 1'b1;
    #0.5;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #0.5;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    burn(k1, 1'b0, 128'h0);
    load(4, -1, 1'b1);
    check(exp_q.size(), 0, "blocks missing");
    test_done();
  end

  // hang guard, well beyond the expected run
  initial
  begin
    #360000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule // tb_top
